// ==== hdl/ebra_top.sv ====
// External bus release and internal bus arbitration
// Contract
// - Release only in expanded mode with enable set
// - On request: acknowledge low, float bus pins
// - Hold internal external accesses while released
// - Drive drop request low when enabled and needed
// - Keep sampling request while released
// - Request high: acknowledge high, take bus back
// - Drop request rises 1.5 clocks after acknowledge
// - Outside release beats same-cycle internal access
// - Internal access and release may run parallel
// - Acknowledge highest-priority requester until withdrawn
// - Transfer controller ranks above CPU
// - CPU yields only between whole bus cycles
// - Sleeping CPU yields to transfer controller at once
// - Transfer controller requests bus on activation
// - Transfer controller yields only after whole operations
// - Release waits for current external cycle end
// - Reset aborts cycles immediately
`timescale 1ns/1ps
`include "ebra_defs.svh"
module ebra_top (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // Mode and control bits
  input wire logic i_expanded_mode,
  input wire logic i_release_enable_bit,
  input wire logic i_drop_request_out_enable,
  // Outside master link
  input wire logic i_ext_bus_request_n,
  output logic o_ext_bus_ack_n,
  output logic o_drop_request_out_n,
  // Internal masters
  input wire logic i_cpu_req,
  input wire logic i_cpu_boundary,
  input wire logic i_cpu_sleep,
  input wire logic i_xfer_activate,
  input wire logic i_xfer_boundary,
  output logic o_cpu_ack,
  output logic o_xfer_ack,
  // External access from the granted internal master
  input wire logic i_ext_access_req,
  input wire logic i_ext_cycle_busy,
  output logic o_ext_access_go,
  input wire ebra_pkg::ebra_bus_type i_bus,
  // External bus pins, output enables low while driven
  output ebra_pkg::ebra_bus_type o_bus,
  output logic o_addr_oe_n,
  output logic o_data_oe_n,
  output logic o_ctrl_oe_n
);
  ebra_pkg::ebra_rel_state_type rel_r;
  ebra_pkg::ebra_rel_state_type rel_nxt;
  logic released;
  logic rel_allowed;
  logic ack_rise;
  logic want_drop;

  // Release is permitted only with the mode and enable both set
  assign rel_allowed = i_expanded_mode & i_release_enable_bit;

  // Release sequencer; the request pin is sampled every cycle except in the return state
  always_comb begin
    rel_nxt = rel_r;
    unique case (rel_r)
      ebra_pkg::EBRA_OWN: begin
        // Request wins over a same-cycle internal start, after current cycle ends
        if (rel_allowed && !i_ext_bus_request_n && !i_ext_cycle_busy) begin
          rel_nxt = ebra_pkg::EBRA_RELEASED;
        end
      end
      ebra_pkg::EBRA_RELEASED: begin
        if (i_ext_bus_request_n) begin
          rel_nxt = ebra_pkg::EBRA_RETURN;
        end
      end
      ebra_pkg::EBRA_RETURN: rel_nxt = ebra_pkg::EBRA_OWN;
      default: rel_nxt = ebra_pkg::EBRA_OWN;
    endcase
  end

  // State register; reset lands in the owned state with release off
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      rel_r <= ebra_pkg::EBRA_OWN;
    end else begin
      rel_r <= rel_nxt;
    end
  end

  // Acknowledge output comes from a flop so it is glitch free
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_ext_bus_ack_n <= 1'b1;
    end else begin
      o_ext_bus_ack_n <= ~(rel_nxt == ebra_pkg::EBRA_RELEASED);
    end
  end

  assign released = (rel_r == ebra_pkg::EBRA_RELEASED);
  assign ack_rise = released & (rel_nxt == ebra_pkg::EBRA_RETURN);

  // External starts are held while released or about to be; internal work goes on
  assign o_ext_access_go = i_ext_access_req & ~released & (rel_r != ebra_pkg::EBRA_RETURN)
    & ~(rel_allowed & ~i_ext_bus_request_n & ~i_ext_cycle_busy);

  // Ask the outside master to let go only when enabled and needed
  assign want_drop = released & i_drop_request_out_enable & i_ext_access_req
    & ~i_ext_bus_request_n;

  ebra_drop_timer u_drop (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_start(ack_rise),
    .i_want(want_drop),
    .o_drop_n(o_drop_request_out_n)
  );

  // Transfer controller asks for the bus whenever it is activated
  ebra_internal_arb u_arb (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_cpu_req(i_cpu_req),
    .i_cpu_boundary(i_cpu_boundary),
    .i_cpu_sleep(i_cpu_sleep),
    .i_xfer_req(i_xfer_activate),
    .i_xfer_boundary(i_xfer_boundary),
    .o_cpu_ack(o_cpu_ack),
    .o_xfer_ack(o_xfer_ack)
  );

  // Bus pins registered; reset returns them to idle levels at once
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_bus <= '{addr: 24'h0, wdata: 16'h0, data_oe: 1'b0, chip_select_n: 8'hff,
                 address_strobe_n: 1'b1, read_strobe_n: 1'b1,
                 upper_write_strobe_n: 1'b1, lower_write_strobe_n: 1'b1};
    end else begin
      o_bus <= i_bus;
    end
  end

  // Floating during release; read strobe may go straight from low to float
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_addr_oe_n <= 1'b0;
      o_ctrl_oe_n <= 1'b0;
      o_data_oe_n <= 1'b1;
    end else begin
      o_addr_oe_n <= (rel_nxt == ebra_pkg::EBRA_RELEASED);
      o_ctrl_oe_n <= (rel_nxt == ebra_pkg::EBRA_RELEASED);
      o_data_oe_n <= (rel_nxt == ebra_pkg::EBRA_RELEASED) | ~i_bus.data_oe;
    end
  end
endmodule : ebra_top

// ==== inc/ebra_defs.svh ====
// Constants for the external bus release arbiter
`ifndef EBRA_DEFS_SVH
`define EBRA_DEFS_SVH
`define EBRA_ADDR_W 24
`define EBRA_DATA_W 16
`define EBRA_CS_W 8
`define EBRA_CLK_MHZ 40
`define EBRA_DROP_DELAY_HALF_CLK 3
`define EBRA_DROP_DELAY_CYC 2
`define EBRA_REGINFO_STATES 3
`define EBRA_REGINFO_CNT_W 2
`define EBRA_MSTOP_BAD_A 16'hffff
`define EBRA_MSTOP_BAD_B 16'hefff
`endif

// ==== inc/ebra_pkg.sv ====
// Types shared by the external bus release arbiter
package ebra_pkg;
  // External bus outputs driven by the internal master
  typedef struct packed {
    logic [23:0] addr;
    logic [15:0] wdata;
    logic data_oe;
    logic [7:0] chip_select_n;
    logic address_strobe_n;
    logic read_strobe_n;
    logic upper_write_strobe_n;
    logic lower_write_strobe_n;
  } ebra_bus_type;

  // Release sequencer states, Gray along the usual path except the return to owned
  typedef enum logic [1:0] {
    EBRA_OWN = 2'b00,
    EBRA_RELEASED = 2'b01,
    EBRA_RETURN = 2'b11
  } ebra_rel_state_type;

  // Internal bus owner
  typedef enum logic [1:0] {
    EBRA_IDLE = 2'b00,
    EBRA_CPU = 2'b01,
    EBRA_XFER = 2'b11
  } ebra_owner_type;
endpackage : ebra_pkg

// ==== hdl/ebra_drop_timer.sv ====
// Delay from acknowledge rise to drop-request-out rise, in half clocks
`timescale 1ns/1ps
`include "ebra_defs.svh"
module ebra_drop_timer (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // Control
  input wire logic i_start,
  input wire logic i_want,
  // Status
  output logic o_drop_n
);
  logic [1:0] cnt_r;
  logic fall_r;
  logic drop_pos_r;

  // One whole clock after acknowledge rises, then the falling-edge stage adds the half
  // Loading the full count here would push the rise out to 2.5 clocks
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      cnt_r <= 2'h0;
    end else if (i_start) begin
      cnt_r <= 2'(`EBRA_DROP_DELAY_CYC - 1);
    end else if (cnt_r != 2'h0) begin
      cnt_r <= cnt_r - 2'h1;
    end
  end

  // Output asserted low on request, released only after the count ends
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      drop_pos_r <= 1'b1;
    end else if (i_want) begin
      drop_pos_r <= 1'b0;
    end else if (cnt_r == 2'h1) begin
      drop_pos_r <= 1'b1;
    end
  end

  // Rise moves to the falling edge, giving 1.5 clocks in total
  always_ff @(negedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      fall_r <= 1'b1;
    end else if (!drop_pos_r) begin
      fall_r <= 1'b0;
    end else begin
      fall_r <= 1'b1;
    end
  end

  assign o_drop_n = drop_pos_r & (fall_r | ~drop_pos_r);
endmodule : ebra_drop_timer

// ==== hdl/ebra_internal_arb.sv ====
// Fixed-priority internal bus arbiter: transfer controller over CPU
`timescale 1ns/1ps
`include "ebra_defs.svh"
module ebra_internal_arb (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // Requests and release points
  input wire logic i_cpu_req,
  input wire logic i_cpu_boundary,
  input wire logic i_cpu_sleep,
  input wire logic i_xfer_req,
  input wire logic i_xfer_boundary,
  // Grants
  output logic o_cpu_ack,
  output logic o_xfer_ack
);
  ebra_pkg::ebra_owner_type owner_r;
  ebra_pkg::ebra_owner_type owner_nxt;

  // Owner yields to the other master only at its own release points; a CPU owner without a request goes idle at once
  always_comb begin
    owner_nxt = owner_r;
    unique case (owner_r)
      ebra_pkg::EBRA_IDLE: begin
        if (i_xfer_req) begin
          owner_nxt = ebra_pkg::EBRA_XFER;
        end else if (i_cpu_req) begin
          owner_nxt = ebra_pkg::EBRA_CPU;
        end
      end
      ebra_pkg::EBRA_CPU: begin
        if (i_xfer_req && (i_cpu_boundary || i_cpu_sleep)) begin
          owner_nxt = ebra_pkg::EBRA_XFER;
        end else if (!i_cpu_req) begin
          owner_nxt = ebra_pkg::EBRA_IDLE;
        end
      end
      ebra_pkg::EBRA_XFER: begin
        if (!i_xfer_req && i_xfer_boundary) begin
          owner_nxt = i_cpu_req ? ebra_pkg::EBRA_CPU : ebra_pkg::EBRA_IDLE;
        end
      end
      default: owner_nxt = ebra_pkg::EBRA_IDLE;
    endcase
  end

  // Reset drops every grant at once
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      owner_r <= ebra_pkg::EBRA_IDLE;
    end else begin
      owner_r <= owner_nxt;
    end
  end

  assign o_cpu_ack = (owner_r == ebra_pkg::EBRA_CPU);
  assign o_xfer_ack = (owner_r == ebra_pkg::EBRA_XFER);
endmodule : ebra_internal_arb

// ==== verification/ebra_top_props.sv ====
// Port-level assertions for the external bus release arbiter
`timescale 1ns/1ps
module ebra_top_props (
  // Clock, reset and control bits
  input wire logic i_mclk, i_rst, i_expanded_mode, i_release_enable_bit, i_drop_request_out_enable,
  // Outside master link
  input wire logic i_ext_bus_request_n, o_ext_bus_ack_n, o_drop_request_out_n,
  // Internal masters and pin enables
  input wire logic i_cpu_req, i_cpu_boundary, i_cpu_sleep, i_xfer_activate, o_cpu_ack, o_xfer_ack,
  input wire logic i_ext_access_req, i_ext_cycle_busy, o_ext_access_go, o_addr_oe_n, o_data_oe_n, o_ctrl_oe_n
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  // A grant needs the mode, the enable and a finished external cycle
  property p_en; $fell(o_ext_bus_ack_n) |-> $past(i_expanded_mode & i_release_enable_bit & ~i_ext_cycle_busy); endproperty
  a_en: assert property (p_en) else $error("release granted while not allowed");
  property p_float; !o_ext_bus_ack_n |-> o_addr_oe_n & o_ctrl_oe_n & o_data_oe_n; endproperty
  a_float: assert property (p_float) else $error("bus driven while released");
  property p_hold; !o_ext_bus_ack_n & !i_ext_bus_request_n |=> !o_ext_bus_ack_n; endproperty
  a_hold: assert property (p_hold) else $error("release ended while still requested");
  property p_end; !o_ext_bus_ack_n & i_ext_bus_request_n |=> o_ext_bus_ack_n; endproperty
  a_end: assert property (p_end) else $error("acknowledge not withdrawn");
  property p_defer; !o_ext_bus_ack_n |-> !o_ext_access_go; endproperty
  a_defer: assert property (p_defer) else $error("external access started while released");
  // Registered drop request may land up to two edges later
  property p_drop; !o_ext_bus_ack_n & !i_ext_bus_request_n & i_drop_request_out_enable & i_ext_access_req
    |-> ##[0:2] !o_drop_request_out_n; endproperty
  a_drop: assert property (p_drop) else $error("drop request not raised");
  // Rise lands on the falling edge 1.5 clocks after acknowledge, so the next rising edge sees it high
  property p_rise; $rose(o_ext_bus_ack_n) & !o_drop_request_out_n |=> o_drop_request_out_n;
  endproperty
  a_rise: assert property (p_rise) else $error("drop request rise mistimed");
  property p_prio; !o_cpu_ack & !o_xfer_ack & i_xfer_activate |-> ##[1:2] o_xfer_ack; endproperty
  a_prio: assert property (p_prio) else $error("transfer controller not preferred");
  property p_keep; o_cpu_ack & i_cpu_req & !i_cpu_boundary & !i_cpu_sleep |=> o_cpu_ack; endproperty
  a_keep: assert property (p_keep) else $error("bus taken from cpu mid cycle");
  property p_sleep; o_cpu_ack & i_cpu_sleep & i_xfer_activate |=> o_xfer_ack; endproperty
  a_sleep: assert property (p_sleep) else $error("sleeping cpu kept the bus");
  c_rel: cover property ($fell(o_ext_bus_ack_n));
  c_drop: cover property ($fell(o_drop_request_out_n));
  c_swap: cover property (o_cpu_ack ##1 o_xfer_ack);
endmodule : ebra_top_props
bind ebra_top ebra_top_props u_props (.*);

// ==== verification/ebra_ext_master.sv ====
// Outside bus master model that asks for and returns the external bus
`timescale 1ns/1ps
module ebra_ext_master (
  // Clock and bench controls
  input wire logic i_mclk,
  input wire logic i_want,
  input wire logic i_prompt,
  // Device link
  input wire logic i_drop_request_out_n,
  output logic o_ext_bus_request_n = 1'b1
);
  // Hold the request while wanted; a prompt master gives way when asked, a slow one ignores it
  always @(negedge i_mclk) begin
    o_ext_bus_request_n <= !(i_want && !(i_prompt && !i_drop_request_out_n));
  end
endmodule : ebra_ext_master

// ==== verification/ext_bus_release_arbiter_tb.sv ====
// Self-checking bench for the external bus release arbiter
`timescale 1ns/1ps
module ext_bus_release_arbiter_tb;
  logic i_mclk = 1'b0, i_rst = 1'b1, i_expanded_mode = 1'b0, i_release_enable_bit = 1'b0;
  logic i_drop_request_out_enable = 1'b0, i_ext_access_req = 1'b0, i_ext_cycle_busy = 1'b0, want = 1'b0;
  logic i_cpu_req = 1'b0, i_cpu_boundary = 1'b1, i_cpu_sleep = 1'b0, i_xfer_activate = 1'b0;
  logic i_xfer_boundary = 1'b1, prompt = 1'b0, take;
  logic i_ext_bus_request_n, o_ext_bus_ack_n, o_drop_request_out_n, o_cpu_ack, o_xfer_ack, o_ext_access_go;
  logic o_addr_oe_n, o_data_oe_n, o_ctrl_oe_n;
  ebra_pkg::ebra_bus_type i_bus = '0, o_bus;
  int n_mismatch = 0, checks_done = 0, cyc_cnt = 0, rs = 0, own = 0;
  ebra_top uut (.*);
  ebra_ext_master u_mst (.i_mclk, .i_want(want), .i_prompt(prompt), .i_drop_request_out_n(o_drop_request_out_n),
    .o_ext_bus_request_n(i_ext_bus_request_n));
  always #12.5 i_mclk = ~i_mclk;
  assign take = i_expanded_mode & i_release_enable_bit & ~i_ext_bus_request_n & ~i_ext_cycle_busy;
  // Reference sequencer: 0 owned, 1 released, 2 returning for one cycle
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) rs <= 0;
    else if (rs == 0) rs <= take ? 1 : 0;
    else if (rs == 1) rs <= i_ext_bus_request_n ? 2 : 1;
    else rs <= 0;
  end
  // Reference owner: 0 idle, 1 CPU, 2 transfer controller, which outranks the CPU
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) own <= 0;
    else if (own == 0) own <= i_xfer_activate ? 2 : (i_cpu_req ? 1 : 0);
    else if (own == 1) own <= (i_xfer_activate && (i_cpu_boundary || i_cpu_sleep)) ? 2 : (i_cpu_req ? 1 : 0);
    else own <= (!i_xfer_activate && i_xfer_boundary) ? (i_cpu_req ? 1 : 0) : 2;
  end
  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge i_mclk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 3000) begin
      n_mismatch++;
      complete_run();
    end
  end
  task automatic check_val(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check_val
  // Compare against the model at each falling edge, before new stimulus lands
  task automatic cyc(input int n);
    repeat (n) begin
      @(negedge i_mclk);
      check_val(o_ext_bus_ack_n, rs != 1);
      check_val({o_addr_oe_n, o_ctrl_oe_n, o_data_oe_n}, {rs == 1, rs == 1, (rs == 1) | ~i_bus.data_oe});
      check_val({o_xfer_ack, o_cpu_ack}, {own == 2, own == 1});
      if (rs != 0 || take) check_val(o_ext_access_go, 0);
    end
  endtask : cyc
  task automatic complete_run;
    $display("checks_done=%0d n_mismatch=%0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : complete_run
  initial begin
    void'($urandom(32'haceb));
    cyc(2);
    i_rst <= 1'b0;
    cyc(1);
    check_val({o_ext_bus_ack_n, o_drop_request_out_n, o_cpu_ack, o_xfer_ack}, 4'hc);
    want <= 1'b1;
    cyc(4);
    check_val(o_ext_bus_ack_n, 1);
    i_expanded_mode <= 1'b1;
    i_release_enable_bit <= 1'b1;
    cyc(3);
    i_drop_request_out_enable <= 1'b1;
    i_ext_access_req <= 1'b1;
    cyc(3);
    check_val({o_ext_bus_ack_n, o_drop_request_out_n}, 0);
    want <= 1'b0;
    // Still low just before the falling edge 1.5 clocks after acknowledge rises, high one edge later
    cyc(3);
    check_val(o_drop_request_out_n, 0);
    cyc(1);
    check_val(o_drop_request_out_n, 1);
    prompt <= 1'b1;
    want <= 1'b1;
    // Third grant is live here, so the reset below has to abort it
    cyc(7);
    i_rst <= 1'b1;
    want <= 1'b0;
    #1 check_val({o_ext_bus_ack_n, o_addr_oe_n, o_bus.address_strobe_n, o_bus.chip_select_n}, 11'h5ff);
    cyc(2);
    i_rst <= 1'b0;
    i_cpu_req <= 1'b1;
    i_xfer_activate <= 1'b1;
    cyc(2);
    check_val({o_xfer_ack, o_cpu_ack}, 2'b10);
    i_xfer_activate <= 1'b0;
    cyc(2);
    check_val({o_xfer_ack, o_cpu_ack}, 2'b01);
    i_cpu_boundary <= 1'b0;
    i_xfer_activate <= 1'b1;
    cyc(3);
    check_val({o_xfer_ack, o_cpu_ack}, 2'b01);
    // No module-stop setting exists on this bench, so sleep is never entered with a barred value
    i_cpu_sleep <= 1'b1;
    cyc(2);
    check_val({o_xfer_ack, o_cpu_ack}, 2'b10);
    i_xfer_boundary <= 1'b0;
    i_xfer_activate <= 1'b0;
    cyc(3);
    check_val({o_xfer_ack, o_cpu_ack}, 2'b10);
    repeat (400) begin
      {want, prompt, i_ext_cycle_busy, i_ext_access_req, i_drop_request_out_enable} <= 5'($urandom);
      {i_cpu_req, i_cpu_boundary, i_cpu_sleep, i_xfer_activate, i_xfer_boundary} <= 5'($urandom);
      i_expanded_mode <= ($urandom % 16) != 0;
      i_release_enable_bit <= ($urandom % 16) != 0;
      i_bus <= 53'({$urandom, $urandom});
      cyc(1);
      check_val(o_bus, i_bus);
    end
    want <= 1'b0;
    cyc(4);
    complete_run();
  end
endmodule : ext_bus_release_arbiter_tb
